// ### core/lvd_ctrl.sv
// Low-voltage detector control: control register, detect flag,
// delayed request flag, wake and interrupt. Analog comparators outside.
// Assumes comparator outputs are synchronous to sys_clk.
//
// Summary of operation
// - Control bit 5 reads 1 while a low voltage is detected, else 0.
// - Control bit 4 switches the detector on when 1 and off when 0.
// - Threshold code 000 compares the external sense pin with the 1.23V reference.
// - Any other code compares the supply with the chosen threshold, 4.0V the highest.
// - The detect flag goes high whenever the detector is on and the monitored voltage is below threshold.
// - In sleep the detector is forced off whatever the enable bit says.
// - Flag consumers tolerate repeated toggling near the threshold.
// - The request flag is raised by hardware only after the detect delay following the flag rising.
// - The request flag goes out as one shared multifunction interrupt source.
// - The request flag being raised by the detect delay wakes the device from idle, unless it is already set.
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl
   import lvd_pkg::*;
#(
   parameter int SETTLE_CYCLES = lvd_pkg::SETTLE_CYC,
   parameter int DELAY_CYCLES  = lvd_pkg::REQ_DELAY_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output var  logic [7:0] reg_rdata,
   input  wire logic       sleep_mode,
   input  wire logic       idle_mode,
   input  wire logic       supply_below,
   input  wire logic       sense_pin_below,
   output var  logic       detector_power,
   output var  logic       use_sense_pin,
   output var  logic [2:0] threshold_select,
   output var  logic       bandgap_enable,
   output var  logic       multifunction_request,
   output var  logic       idle_wake,
   output var  logic       irq
);
   import lvd_pkg::*;

   initial begin
      if (SETTLE_CYCLES < 1 || DELAY_CYCLES < 1) $error("Cycle counts must be at least 1");
   end

   // ***************************************
   // Registers
   // ***************************************
   logic [4:0]  control_reg;
   logic [2:0]  status_reg;
   logic [2:0]  mask_reg;
   logic        lvr_en_reg;
   logic        flag_reg;
   logic        request_reg;
   lvd_state_e  state_reg;
   lvd_state_e  state_next;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_reg;

   wire wr_control = reg_write && (reg_addr == ADDR_CONTROL);
   wire wr_status  = reg_write && (reg_addr == ADDR_IRQ_STATUS);
   wire wr_mask    = reg_write && (reg_addr == ADDR_IRQ_MASK);
   wire wr_misc    = reg_write && (reg_addr == ADDR_MISC);

   wire det_en     = control_reg[BIT_DET_EN];
   wire [2:0] thr  = control_reg[THR_MSB:0];
   // Sleep gates the analog enable directly, not via the bit
   wire det_active = det_en && !sleep_mode;
   wire ext_sel    = (thr == THR_EXT_PIN);
   wire below      = ext_sel ? sense_pin_below : supply_below;
   wire settled    = (state_reg == LVD_RUN);
   wire flag_next  = det_active && below;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) control_reg <= CONTROL_RESET[4:0];
      else if (wr_control) control_reg <= reg_wdata[4:0] & CONTROL_WMASK[4:0];
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) lvr_en_reg <= 1'b0;
      else if (wr_misc) lvr_en_reg <= reg_wdata[BIT_LVR_EN];
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) flag_reg <= 1'b0;
      else          flag_reg <= flag_next;
   end

   // ***************************************
   // Settle tracking
   // ***************************************
   // Status only; the flag is not blanked, software owns the wait
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LVD_OFF:    if (det_active) state_next = LVD_SETTLE;
         LVD_SETTLE: if (!det_active) state_next = LVD_OFF;
                     else if (settle_reg == ($bits(settle_reg))'(SETTLE_CYCLES)) state_next = LVD_RUN;
         LVD_RUN:    if (!det_active) state_next = LVD_OFF;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= LVD_OFF;
         settle_reg <= '0;
      end else begin
         state_reg  <= state_next;
         settle_reg <= (state_reg == LVD_SETTLE) ? settle_reg + 1'b1 : '0;
      end
   end

   // ***************************************
   // Request delay and edges
   // ***************************************
   logic qualified;
   logic flag_rise;
   logic flag_fall;
   logic qual_rise;

   lvd_delay #(.CYCLES(DELAY_CYCLES)) u_delay (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .level_in  (flag_reg),
      .qualified (qualified)
   );

   lvd_edge u_flag_edge (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .level_in (flag_reg),
      .rise     (flag_rise),
      .fall     (flag_fall)
   );

   lvd_edge u_qual_edge (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .level_in (qualified),
      .rise     (qual_rise),
      .fall     ()
   );

   // Software may set the request itself to suppress idle wake
   wire req_set   = qual_rise || (wr_status && reg_wdata[ST_REQ]);
   wire [2:0] ev  = {flag_fall, flag_rise, qual_rise};
   wire [2:0] clr = wr_status ? reg_wdata[2:0] : 3'h0;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= 3'h0;
         mask_reg   <= MASK_RESET[2:0];
      end else begin
         // Set wins over clear
         status_reg <= (status_reg & ~clr) | ev;
         if (wr_mask) mask_reg <= reg_wdata[2:0];
      end
   end

   // Request flag: write 1 sets, write 0 with bit 7 set clears (interrupt controller style)
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) request_reg <= 1'b0;
      else if (req_set) request_reg <= 1'b1;
      else if (wr_status && reg_wdata[ST_REQ] == 1'b0 && reg_wdata[7]) request_reg <= 1'b0;
   end

   // ***************************************
   // Read path and outputs
   // ***************************************
   wire [7:0] rd_control = {2'b00, flag_reg, control_reg};
   wire [7:0] rd_status  = {settled, 4'h0, status_reg[2:1], request_reg};
   wire [7:0] rd_mux = (reg_addr == ADDR_CONTROL)    ? rd_control :
                       (reg_addr == ADDR_IRQ_STATUS) ? rd_status :
                       (reg_addr == ADDR_IRQ_MASK)   ? {5'h00, mask_reg} :
                                                       {7'h00, lvr_en_reg};
   wire [2:0] pend   = {status_reg[2:1], request_reg} & mask_reg;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata             <= 8'h00;
         detector_power        <= 1'b0;
         use_sense_pin         <= 1'b0;
         threshold_select      <= 3'h0;
         bandgap_enable        <= 1'b0;
         multifunction_request <= 1'b0;
         idle_wake             <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         reg_rdata             <= reg_read ? rd_mux : 8'h00;
         detector_power        <= det_active;
         use_sense_pin         <= ext_sel;
         threshold_select      <= thr;
         bandgap_enable        <= control_reg[BIT_BG_EN] || det_en || lvr_en_reg;
         multifunction_request <= request_reg;
         idle_wake             <= idle_mode && qual_rise && !request_reg;
         irq                   <= |pend;
      end
   end

   // ***************************************
   // Check helpers
   // ***************************************
   // Run length of the flag, checks only; saturates past the delay
   localparam int RUN_W = $clog2(DELAY_CYCLES + 3);
   logic [RUN_W-1:0] flag_run_reg;
   wire              run_full = (flag_run_reg == RUN_W'(DELAY_CYCLES + 2));

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) flag_run_reg <= '0;
      else          flag_run_reg <= !flag_reg ? '0 : (run_full ? flag_run_reg : flag_run_reg + 1'b1);
   end

   // ***************************************
   // Checks
   // ***************************************
   chk_flag_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_read && reg_addr == ADDR_CONTROL |=> reg_rdata[BIT_FLAG] == $past(flag_reg))
      else $error("Flag bit read wrong");
   chk_high_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $past(reg_read && reg_addr == ADDR_CONTROL) |-> reg_rdata[7:6] == 2'b00)
      else $error("Reserved bits not zero");
   chk_sleep_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sleep_mode |=> !detector_power)
      else $error("Detector on in sleep");
   chk_enable_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
      det_en && !sleep_mode |=> detector_power)
      else $error("Detector not powered");
   chk_src_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
      thr == THR_EXT_PIN && det_active && sense_pin_below |=> flag_reg)
      else $error("Sense pin not monitored");
   chk_supply_cmp: assert property (@(posedge sys_clk) disable iff (!reset_n)
      thr != THR_EXT_PIN && det_active |=> flag_reg == $past(supply_below))
      else $error("Supply compare wrong");
   chk_req_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
      qual_rise == (flag_run_reg == RUN_W'(DELAY_CYCLES + 1)))
      else $error("Request not at detect delay");
   chk_req_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      request_reg && !wr_status |=> request_reg)
      else $error("Request flag lost");
   chk_mf_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
      request_reg |=> multifunction_request)
      else $error("Shared request not driven");
   chk_mf_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !request_reg |=> !multifunction_request)
      else $error("Shared request without flag");
   chk_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
      request_reg && mask_reg[ST_REQ] |=> irq)
      else $error("Unmasked request without irq");
   chk_bg_force: assert property (@(posedge sys_clk) disable iff (!reset_n)
      det_en || lvr_en_reg |=> bandgap_enable)
      else $error("Bandgap not forced");
   chk_bg_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
      control_reg[BIT_BG_EN] |=> bandgap_enable)
      else $error("Bandgap bit ignored");
   chk_bg_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !control_reg[BIT_BG_EN] && !det_en && !lvr_en_reg |=> !bandgap_enable)
      else $error("Bandgap on without cause");
   chk_wake_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      idle_mode && qual_rise && !request_reg |=> idle_wake)
      else $error("No idle wake");
   chk_wake_no_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !idle_mode |=> !idle_wake)
      else $error("Wake outside idle");
   chk_wake_suppress: assert property (@(posedge sys_clk) disable iff (!reset_n)
      request_reg |=> !idle_wake)
      else $error("Wake with request already set");
   chk_rise_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
      flag_rise |=> status_reg[ST_RISE])
      else $error("Flag rise not recorded");
   chk_fall_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
      flag_fall |=> status_reg[ST_FALL])
      else $error("Flag fall not recorded");
   chk_status_w1c: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_status && reg_wdata[ST_RISE] && !flag_rise |=> !status_reg[ST_RISE])
      else $error("Rise status not cleared");
   chk_power_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !det_en |=> !detector_power)
      else $error("Detector powered while disabled");
   chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_control |=> control_reg == $past(reg_wdata[4:0]))
      else $error("Control write lost");
   chk_sleep_unsettle: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sleep_mode |=> !settled)
      else $error("Settled while asleep");
   chk_flag_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !det_active |=> !flag_reg)
      else $error("Flag set while detector off");
   chk_ext_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
      thr == THR_EXT_PIN && det_active && !sense_pin_below |=> !flag_reg)
      else $error("Supply used in pin mode");
   chk_thr_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
      wr_control |-> ##2 threshold_select == $past(reg_wdata[2:0], 2))
      else $error("Threshold code not driven");

   // ***************************************
   // Cover points
   // ***************************************
   cov_detect: cover property (@(posedge sys_clk) disable iff (!reset_n) flag_rise);
   cov_request: cover property (@(posedge sys_clk) disable iff (!reset_n) qual_rise);
   cov_toggle: cover property (@(posedge sys_clk) disable iff (!reset_n) flag_fall ##[1:20] flag_rise);
   cov_sleep: cover property (@(posedge sys_clk) disable iff (!reset_n) det_en && sleep_mode);
   cov_wake: cover property (@(posedge sys_clk) disable iff (!reset_n) idle_wake);
endmodule // lvd_ctrl
`default_nettype wire

// ### core/lvd_pkg.sv
// Constants shared by the low-voltage detect control logic.
// Assumes an 8-bit register port clocked by sys_clk at 10 MHz.
package lvd_pkg;
   // ***************************************
   // Register map
   // ***************************************
   localparam logic [1:0] ADDR_CONTROL      = 2'h0;
   localparam logic [1:0] ADDR_IRQ_STATUS   = 2'h1;
   localparam logic [1:0] ADDR_IRQ_MASK     = 2'h2;
   localparam logic [1:0] ADDR_MISC         = 2'h3;
   localparam logic [7:0] CONTROL_RESET     = 8'h00;
   localparam logic [7:0] MASK_RESET        = 8'h00;
   // ***************************************
   // Control field positions
   // ***************************************
   localparam int         BIT_FLAG          = 5;
   localparam int         BIT_DET_EN        = 4;
   localparam int         BIT_BG_EN         = 3;
   localparam int         THR_MSB           = 2;
   localparam logic [7:0] CONTROL_WMASK     = 8'h1F;
   localparam logic [2:0] THR_EXT_PIN       = 3'h0;
   // Status bits: 0 request flag, 1 flag rise, 2 flag fall
   localparam int         ST_REQ            = 0;
   localparam int         ST_RISE           = 1;
   localparam int         ST_FALL           = 2;
   // Misc register: bit 0 low-voltage reset enable
   localparam int         BIT_LVR_EN        = 0;
   // ***************************************
   // Timing
   // ***************************************
   localparam int         CLK_PERIOD_NS     = 100;
   localparam int         SETTLE_NS         = 15000;
   localparam int         REQ_DELAY_NS      = 15000;
   localparam int         SETTLE_CYC        = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         REQ_DELAY_CYC     = (REQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {LVD_OFF, LVD_SETTLE, LVD_RUN} lvd_state_e;
endpackage : lvd_pkg

// ### core/lvd_delay.sv
// Delay qualifier: output rises after input held high for a cycle count.
// Assumes input is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lvd_delay #(
   parameter int CYCLES = 150
) (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic level_in,
   output var  logic qualified
);
   localparam int CW = $clog2(CYCLES + 1);
   initial begin
      if (CYCLES < 1) $error("CYCLES must be at least 1");
   end
   logic [CW-1:0] count_reg;
   wire           done = (count_reg == CW'(CYCLES));
   // Restart on every drop so chatter near threshold never shortens the wait
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
         qualified <= 1'b0;
      end else begin
         count_reg <= !level_in ? '0 : (done ? count_reg : count_reg + 1'b1);
         qualified <= level_in && done;
      end
   end
endmodule // lvd_delay
`default_nettype wire

// ### core/lvd_edge.sv
// Rising and falling edge pulses of a synchronous level.
// Assumes input is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module lvd_edge (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic level_in,
   output wire logic rise,
   output wire logic fall
);
   logic last_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) last_reg <= 1'b0;
      else          last_reg <= level_in;
   end
   assign rise = level_in & ~last_reg;
   assign fall = ~level_in & last_reg;
endmodule // lvd_edge
`default_nettype wire

// ### bench/lvd_ctrl_bench.sv
// Self-checking bench for the low-voltage detect control block.
// Assumes lvd_pkg is compiled first; short delay counts of 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl_bench;
   import lvd_pkg::*;
   localparam int D = 3;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic       sleep_mode = 1'b0;
   logic       idle_mode = 1'b0;
   logic       supply_below = 1'b0;
   logic       sense_pin_below = 1'b0;
   logic       detector_power;
   logic       use_sense_pin;
   logic [2:0] threshold_select;
   logic       bandgap_enable;
   logic       multifunction_request;
   logic       idle_wake;
   logic       irq;
   logic [7:0] exp_q[$];
   logic       rd_due = 1'b0;
   logic [2:0] c;
   logic       sp;
   logic       sb;
   int         fail_count = 0;
   int         n_checks = 0;
   int         wake_cnt = 0;
   int         w0;
   int         cnt;

   always #50 sys_clk = ~sys_clk;

   lvd_ctrl #(.SETTLE_CYCLES(3), .DELAY_CYCLES(D)) lvd_ctrl_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
      .idle_mode(idle_mode), .supply_below(supply_below), .sense_pin_below(sense_pin_below),
      .detector_power(detector_power), .use_sense_pin(use_sense_pin), .threshold_select(threshold_select),
      .bandgap_enable(bandgap_enable), .multifunction_request(multifunction_request),
      .idle_wake(idle_wake), .irq(irq));

   // ***************************************
   // Checking and closing
   // ***************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge sys_clk) begin
      if (rd_due) begin
         if (exp_q.size() == 0) check(reg_rdata, 8'hxx);
         else check(reg_rdata, exp_q.pop_front());
      end
      rd_due <= reg_read;
      if (idle_wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end

   // ***************************************
   // Bus tasks, entered just after a rising edge
   // ***************************************
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_read <= 1'b1;
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Ends at a falling edge so level outputs have settled
   task automatic pause(input int n);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_of_test();
   end

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      void'($urandom(32'hceca_c768));
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(ADDR_CONTROL, 8'h00);
      rd(ADDR_IRQ_STATUS, 8'h00);
      rd(ADDR_IRQ_MASK, 8'h00);
      rd(ADDR_MISC, 8'h00);
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         // Pin and supply differ, so a wrong source shows in the flag
         sp = (c == 3'h0) ? 1'b1 : 1'($urandom);
         sb = ~sp;
         sense_pin_below <= sp;
         supply_below <= sb;
         wr(ADDR_CONTROL, {5'h02, c});
         pause(5);
         check({5'h00, threshold_select}, {5'h00, c});
         check({7'h00, use_sense_pin}, {7'h00, c == 3'h0});
         check({6'h00, detector_power, bandgap_enable}, 8'h03);
         @(posedge sys_clk);
         rd(ADDR_CONTROL, {2'b00, (c == 3'h0) ? sp : sb, 2'b10, c});
      end
      supply_below <= 1'b0;
      sense_pin_below <= 1'b0;
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, 8'h1f);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_MISC, 8'h01);
      pause(3);
      check({6'h00, detector_power, bandgap_enable}, 8'h01);
      @(posedge sys_clk);
      wr(ADDR_MISC, 8'h00);
      pause(3);
      check({7'h00, bandgap_enable}, 8'h00);
      @(posedge sys_clk);
      // Enabled but asleep: detector must stay off while the supply is low
      sleep_mode <= 1'b1;
      supply_below <= 1'b1;
      wr(ADDR_CONTROL, 8'h11);
      pause(8);
      check({7'h00, detector_power}, 8'h00);
      @(posedge sys_clk);
      rd(ADDR_CONTROL, 8'h11);
      sleep_mode <= 1'b0;
      supply_below <= 1'b0;
      wr(ADDR_IRQ_MASK, 8'h01);
      pause(4);
      @(posedge sys_clk);
      wr(ADDR_IRQ_STATUS, 8'h86);
      rd(ADDR_IRQ_STATUS, 8'h80);
      // Short pulses shorter than the delay never raise the request
      idle_mode <= 1'b1;
      repeat (3) begin
         supply_below <= 1'b1;
         pause(1);
         @(posedge sys_clk);
         supply_below <= 1'b0;
         pause(1);
         @(posedge sys_clk);
      end
      pause(2);
      @(posedge sys_clk);
      rd(ADDR_IRQ_STATUS, 8'h86);
      wr(ADDR_IRQ_STATUS, 8'h86);
      w0 = wake_cnt;
      supply_below <= 1'b1;
      pause(1);
      @(posedge sys_clk);
      rd(ADDR_IRQ_STATUS, 8'h82);
      // Strobe down; cycles counted from the supply going low
      pause(0);
      cnt = 3;
      while (multifunction_request !== 1'b1 && cnt < 40) begin
         @(negedge sys_clk);
         cnt++;
      end
      if (cnt >= 40) begin
         fail_count++;
         end_of_test();
      end
      // Flag one cycle, delay D+1, request one, shared copy one
      check(8'(cnt), 8'(D + 4));
      pause(2);
      check({7'h00, irq}, 8'h01);
      check(8'(wake_cnt - w0), 8'h01);
      @(posedge sys_clk);
      wr(ADDR_IRQ_MASK, 8'h00);
      pause(2);
      check({7'h00, irq}, 8'h00);
      @(posedge sys_clk);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_IRQ_STATUS, 8'h80);
      pause(3);
      check({6'h00, irq, multifunction_request}, 8'h00);
      @(posedge sys_clk);
      // Request set by software first, so a later detect must not wake
      supply_below <= 1'b0;
      wr(ADDR_IRQ_STATUS, 8'h06);
      wr(ADDR_IRQ_STATUS, 8'h01);
      pause(3);
      w0 = wake_cnt;
      check({7'h00, multifunction_request}, 8'h01);
      @(posedge sys_clk);
      supply_below <= 1'b1;
      pause(D + 10);
      check(8'(wake_cnt - w0), 8'h00);
      end_of_test();
   end
endmodule // lvd_ctrl_bench
`default_nettype wire
